// ===== core/resp_ctrl.sv
// Decided for this implementation: the APB register port and the address map.
module resp_ctrl
	import resp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [resp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic gpio_func_o,
	input wire logic gpio_func_oe,
	output logic general_pin_three_o,
	output logic general_pin_three_oe,
	output logic respiration_enable,
	output logic ext_amp_bypass,
	output logic ext_capacitor_sel,
	output logic [3:0] gain_mult,
	output resp_pkg::lead_t measure_lead_sel,
	output logic ext_in_right_arm,
	output logic ext_in_left_arm,
	output logic ext_in_left_leg,
	output logic drive_out_left_leg,
	output logic drive_out_right_arm,
	output logic drive_out_left_arm,
	output logic [1:0] tone_amplitude_sel,
	output logic [1:0] carrier_freq_sel,
	output logic every_cycle_periodic,
	output logic sync_constant_period
);
	import resp_pkg::*;

	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [31:0] status;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_status;
	logic en_bit;
	logic cap_bit;
	logic [3:0] gain_code;
	lead_t lead_code;
	logic ext_path;
	logic [3:0] gain_q;
	logic [3:0] gain_d;
	lead_t lead_q;
	logic [2:0] drv_q;
	logic [2:0] drv_d;
	logic [2:0] ext_q;
	logic [2:0] ext_d;
	logic [5:0] misc_q;
	logic [5:0] misc_d;
	logic [1:0] pin_q;
	logic [1:0] pin_d;

	carrier_if carrier ();

	// Address decode and phase flags of the APB slave.
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_ctrl = (paddr == CTRL_ADDR);
	assign hit_status = (paddr == STATUS_ADDR);
	assign pready = 1'b1;
	assign pslverr = access && !hit_ctrl && !hit_status;
	assign prdata = prdata_q;

	// Field views of the control register.
	assign en_bit = ctrl_q[B_ENABLE];
	assign cap_bit = ctrl_q[B_CAP];
	assign gain_code = ctrl_q[B_GAIN +: 4];
	assign lead_code = lead_t'(ctrl_q[B_LEAD +: 2]);
	assign ext_path = (lead_code == LEAD_EXT);

	// Write path; unused upper bits are dropped so they read as zero.
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (access && pwrite && hit_ctrl)
			ctrl_d = pwdata[CTRL_W-1:0] & CTRL_MASK;
	end

	// Status word built from the block's own decoded state.
	always_comb
	begin
		status = 32'h00000000;
		status[S_GAIN +: 4] = gain_q;
		status[S_DRV_LL] = drv_q[0];
		status[S_DRV_RA] = drv_q[1];
		status[S_DRV_LA] = drv_q[2];
		status[S_EXT_LL] = ext_q[0];
		status[S_EXT_RA] = ext_q[1];
		status[S_EXT_LA] = ext_q[2];
		status[S_DAC_MSB] = carrier.dac_msb;
		status[S_CONST] = misc_q[5];
	end

	// Read data is captured in the setup phase and held for the access.
	always_comb
	begin
		prdata_d = prdata_q;
		if (setup)
		begin
			if (!pwrite && hit_ctrl)
				prdata_d = {8'h00, ctrl_q & CTRL_MASK};
			else if (!pwrite && hit_status)
				prdata_d = status;
			else
				prdata_d = 32'h00000000;
		end
	end

	// Bus-facing registers.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RESET;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
		end
	end

	// Carrier generator fed from the frequency and periodicity fields.
	assign carrier.enable = en_bit;
	assign carrier.every_cycle = ctrl_q[B_PERIODIC];
	assign carrier.freq_sel = ctrl_q[B_FREQ +: 2];

	carrier_gen u_gen (
		.clock(clock),
		.rst(rst),
		.c(carrier.gen)
	);

	// Decode the fields into the analog front-end controls.
	always_comb
	begin
		if (gain_code > GAIN_MAX_CODE)
			gain_d = GAIN_SAT;
		else
			gain_d = gain_code + GAIN_STEP;
		drv_d = 3'b000;
		if (en_bit && cap_bit)
			drv_d = 3'b010;
		else if (en_bit && ctrl_q[B_OUTPAIR])
			drv_d = 3'b110;
		else if (en_bit)
			drv_d = 3'b011;
		ext_d = 3'b000;
		if (ext_path)
		begin
			ext_d[1] = 1'b1;
			ext_d[2] = ctrl_q[B_EXTSEL];
			ext_d[0] = !ctrl_q[B_EXTSEL];
		end
		misc_d[0] = en_bit;
		misc_d[1] = ctrl_q[B_BYPASS];
		misc_d[2] = cap_bit;
		misc_d[3] = ctrl_q[B_PERIODIC];
		misc_d[4] = ctrl_q[B_SYNC];
		misc_d[5] = ctrl_q[B_SYNC] && ctrl_q[B_PERIODIC];
	end

	// General pin: carrier MSB when sync is on, else its normal function.
	always_comb
	begin
		if (ctrl_q[B_SYNC])
			pin_d = {1'b1, carrier.dac_msb};
		else
			pin_d = {gpio_func_oe, gpio_func_o};
	end

	// Registered controls toward the analog section and the pin.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			gain_q <= GAIN_STEP;
			lead_q <= LEAD_I;
			drv_q <= 3'b000;
			ext_q <= 3'b000;
			misc_q <= 6'h00;
			pin_q <= 2'b00;
		end
		else
		begin
			gain_q <= gain_d;
			lead_q <= lead_code;
			drv_q <= drv_d;
			ext_q <= ext_d;
			misc_q <= misc_d;
			pin_q <= pin_d;
		end
	end

	// Output assignments; amplitude and frequency codes pass unchanged.
	assign gain_mult = gain_q;
	assign measure_lead_sel = lead_q;
	assign drive_out_left_leg = drv_q[0];
	assign drive_out_right_arm = drv_q[1];
	assign drive_out_left_arm = drv_q[2];
	assign ext_in_left_leg = ext_q[0];
	assign ext_in_right_arm = ext_q[1];
	assign ext_in_left_arm = ext_q[2];
	assign respiration_enable = misc_q[0];
	assign ext_amp_bypass = misc_q[1];
	assign ext_capacitor_sel = misc_q[2];
	assign every_cycle_periodic = misc_q[3];
	assign sync_constant_period = misc_q[5];
	assign tone_amplitude_sel = ctrl_q[B_AMP +: 2];
	assign carrier_freq_sel = ctrl_q[B_FREQ +: 2];
	assign general_pin_three_o = pin_q[0];
	assign general_pin_three_oe = pin_q[1];

	// Gain saturates at ten for codes above nine.
	property p_gain_sat;
		@(posedge clock) disable iff (rst)
		(gain_code > GAIN_MAX_CODE) |=> (gain_mult == GAIN_SAT);
	endproperty
	a_gain_sat: assert property (p_gain_sat)
		else $error("gain did not saturate");

	// Gain follows code plus one below saturation.
	property p_gain_lin;
		@(posedge clock) disable iff (rst)
		(gain_code <= GAIN_MAX_CODE) |=>
			(gain_mult == $past(gain_code) + GAIN_STEP);
	endproperty
	a_gain_lin: assert property (p_gain_lin)
		else $error("gain not code plus one");

	// With sync on, the pin is driven with the carrier MSB.
	property p_pin_sync;
		@(posedge clock) disable iff (rst)
		ctrl_q[B_SYNC] |=> (general_pin_three_oe &&
			general_pin_three_o == $past(carrier.dac_msb));
	endproperty
	a_pin_sync: assert property (p_pin_sync)
		else $error("pin does not carry carrier msb");

	// With sync off, the pin keeps its normal function.
	property p_pin_gpio;
		@(posedge clock) disable iff (rst)
		!ctrl_q[B_SYNC] |=> (general_pin_three_o == $past(gpio_func_o) &&
			general_pin_three_oe == $past(gpio_func_oe));
	endproperty
	a_pin_gpio: assert property (p_pin_gpio)
		else $error("pin lost its normal function");

	// External capacitors force the right-arm drive alone.
	property p_cap_ra;
		@(posedge clock) disable iff (rst)
		(en_bit && cap_bit) |=> (drive_out_right_arm &&
			!drive_out_left_leg && !drive_out_left_arm);
	endproperty
	a_cap_ra: assert property (p_cap_ra)
		else $error("capacitor option did not force right arm");

	// Output pair selection with internal capacitors.
	property p_out_pair;
		@(posedge clock) disable iff (rst)
		(en_bit && !cap_bit) |=> (drive_out_right_arm &&
			drive_out_left_arm == $past(ctrl_q[B_OUTPAIR]) &&
			drive_out_left_leg != $past(ctrl_q[B_OUTPAIR]));
	endproperty
	a_out_pair: assert property (p_out_pair)
		else $error("wrong drive output pair");

	// External input pair applies only on the external path.
	property p_ext_in;
		@(posedge clock) disable iff (rst)
		ext_path |=> (ext_in_right_arm &&
			ext_in_left_arm == $past(ctrl_q[B_EXTSEL]) &&
			ext_in_left_leg == !$past(ctrl_q[B_EXTSEL]));
	endproperty
	a_ext_in: assert property (p_ext_in)
		else $error("wrong external input pair");

	// Lead selections other than external leave external inputs off.
	property p_ext_off;
		@(posedge clock) disable iff (rst)
		!ext_path |=> !(ext_in_right_arm || ext_in_left_arm ||
			ext_in_left_leg) && (measure_lead_sel == $past(lead_code));
	endproperty
	a_ext_off: assert property (p_ext_off)
		else $error("external inputs on outside external path");

	// Bypass and constant-period flags follow their bits.
	property p_bypass;
		@(posedge clock) disable iff (rst)
		1'b1 |=> (ext_amp_bypass == $past(ctrl_q[B_BYPASS]) &&
			sync_constant_period == $past(ctrl_q[B_SYNC] &&
			ctrl_q[B_PERIODIC]));
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass or period flag mismatch");

	// Disabled measurement stops the carrier and drive outputs.
	property p_disable;
		@(posedge clock) disable iff (rst)
		!en_bit |=> (!carrier.dac_msb && !drive_out_right_arm);
	endproperty
	a_disable: assert property (p_disable)
		else $error("carrier runs while disabled");

	// Readback of the control register shows zero in the unused bits.
	property p_readback;
		@(posedge clock) disable iff (rst)
		(access && !pwrite && hit_ctrl) |-> (prdata[31:17] == 15'h0000);
	endproperty
	a_readback: assert property (p_readback)
		else $error("unused bits read non-zero");
endmodule

// ===== core/resp_pkg.sv
// Operation
// - Bit 16 set makes the pin waveform periodic every cycle, else every N.
// - Bit 15 set drives the carrier DAC MSB onto the general pin.
// - The sync signal has constant period only when bit 16 is set.
// - Bit 14 set bypasses the on-chip amplifier straight to the converter.
// - Bit 13 picks drive pair: clear is left leg/right arm, set left arm.
// - External capacitors force the right-arm drive output regardless of bit 13.
// - Bit 12 picks capacitors: clear internal, set external.
// - Gain field gives code plus one, saturating at ten.
// - Bit 7 picks external input pair, only on external path; right arm auto.
// - Lead field selects Lead I, II, III or the external path.
// - Amplitude field gives one eighth, quarter, half or full tone.
// - Frequency field selects carrier frequency together with bit 16.
// - Codes give 56/54/52/50 kHz, or 64/56.9/51.2/46.5 kHz periodic.
// - Bit 0 enables respiration measurement, off by default.
package resp_pkg;
	// Register map; the control register index is scaled by four on APB.
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] CTRL_INDEX = 8'h03;
	localparam logic [7:0] STATUS_INDEX = 8'h10;
	localparam logic [7:0] CTRL_ADDR = 8'(CTRL_INDEX * 4);
	localparam logic [7:0] STATUS_ADDR = 8'(STATUS_INDEX * 4);
	localparam int unsigned CTRL_W = 24;
	localparam int unsigned CTRL_USED = 17;
	localparam logic [23:0] CTRL_RESET = 24'h000000;
	localparam logic [23:0] CTRL_MASK = 24'h01FFFF;

	// Field positions of the control register.
	localparam int unsigned B_PERIODIC = 16;
	localparam int unsigned B_SYNC = 15;
	localparam int unsigned B_BYPASS = 14;
	localparam int unsigned B_OUTPAIR = 13;
	localparam int unsigned B_CAP = 12;
	localparam int unsigned B_GAIN = 8;
	localparam int unsigned B_EXTSEL = 7;
	localparam int unsigned B_LEAD = 5;
	localparam int unsigned B_AMP = 3;
	localparam int unsigned B_FREQ = 1;
	localparam int unsigned B_ENABLE = 0;

	// Gain saturation.
	localparam logic [3:0] GAIN_MAX_CODE = 4'h9;
	localparam logic [3:0] GAIN_SAT = 4'hA;
	localparam logic [3:0] GAIN_STEP = 4'h1;

	// Measurement source selection.
	typedef enum logic [1:0] {
		LEAD_I = 2'b00,
		LEAD_II = 2'b01,
		LEAD_III = 2'b10,
		LEAD_EXT = 2'b11
	} lead_t;

	// Carrier frequencies in Hz, plain and every-cycle periodic.
	localparam longint CLK_HZ = 10000000;
	localparam longint F_N0 = 56000;
	localparam longint F_N1 = 54000;
	localparam longint F_N2 = 52000;
	localparam longint F_N3 = 50000;
	localparam longint F_P0 = 64000;
	localparam longint F_P1 = 56900;
	localparam longint F_P2 = 51200;
	localparam longint F_P3 = 46500;
	localparam longint PHASE_ONE = 65536;

	// Phase steps for the fractional (every N cycles) generator.
	localparam logic [15:0] STEP_0 = 16'(F_N0 * PHASE_ONE / CLK_HZ);
	localparam logic [15:0] STEP_1 = 16'(F_N1 * PHASE_ONE / CLK_HZ);
	localparam logic [15:0] STEP_2 = 16'(F_N2 * PHASE_ONE / CLK_HZ);
	localparam logic [15:0] STEP_3 = 16'(F_N3 * PHASE_ONE / CLK_HZ);

	// Whole periods in clock cycles for the every-cycle generator.
	localparam logic [7:0] PER_0 = 8'((CLK_HZ + F_P0 / 2) / F_P0);
	localparam logic [7:0] PER_1 = 8'((CLK_HZ + F_P1 / 2) / F_P1);
	localparam logic [7:0] PER_2 = 8'((CLK_HZ + F_P2 / 2) / F_P2);
	localparam logic [7:0] PER_3 = 8'((CLK_HZ + F_P3 / 2) / F_P3);

	// Status register layout.
	localparam int unsigned S_GAIN = 0;
	localparam int unsigned S_DRV_LL = 4;
	localparam int unsigned S_DRV_RA = 5;
	localparam int unsigned S_DRV_LA = 6;
	localparam int unsigned S_EXT_LL = 7;
	localparam int unsigned S_EXT_RA = 8;
	localparam int unsigned S_EXT_LA = 9;
	localparam int unsigned S_DAC_MSB = 10;
	localparam int unsigned S_CONST = 11;
endpackage

// ===== core/carrier_if.sv
// Carrier generator controls and the DAC most significant bit.
interface carrier_if;
	logic enable;
	logic every_cycle;
	logic [1:0] freq_sel;
	logic dac_msb;

	modport gen (input enable, input every_cycle, input freq_sel,
		output dac_msb);
	modport ctl (output enable, output every_cycle, output freq_sel,
		input dac_msb);
endinterface

// ===== core/carrier_gen.sv
module carrier_gen
	import resp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	carrier_if.gen c
);
	logic [15:0] phase_q;
	logic [15:0] phase_d;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic msb_q;
	logic msb_d;
	logic [15:0] step;
	logic [7:0] period;

	// Periodic mode counts whole cycles; otherwise a fractional phase
	// accumulator gives the mean rate to within one truncated phase step, with a jittering period.
	always_comb
	begin
		// Fractional steps give the plain rates of the frequency codes.
		case (c.freq_sel)
			2'b00: step = STEP_0;
			2'b01: step = STEP_1;
			2'b10: step = STEP_2;
			default: step = STEP_3;
		endcase
		// Whole periods give the every-cycle rates of the same codes.
		case (c.freq_sel)
			2'b00: period = PER_0;
			2'b01: period = PER_1;
			2'b10: period = PER_2;
			default: period = PER_3;
		endcase
		phase_d = 16'h0000;
		count_d = 8'h00;
		msb_d = 1'b0;
		if (c.enable && c.every_cycle)
		begin
			count_d = (count_q >= period - 8'h01) ? 8'h00 : count_q + 8'h01;
			msb_d = (count_d < {1'b0, period[7:1]});
		end
		else if (c.enable)
		begin
			phase_d = phase_q + step;
			msb_d = phase_d[15];
		end
	end

	// Generator state registers.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			phase_q <= 16'h0000;
			count_q <= 8'h00;
			msb_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			count_q <= count_d;
			msb_q <= msb_d;
		end
	end

	assign c.dac_msb = msb_q;
endmodule

// ===== verification/sync_receiver.sv
// External receiver that measures the period and counts rising edges of the carrier sync pin.
module sync_receiver
(
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic [15:0] period,
	output logic [15:0] rises
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_q;
	logic last_q;

	// Measure cycles between rising edges; the pin may be pulled up when idle.
	always @(posedge clock)
	begin
		if (rst)
		begin
			cnt_q <= 16'h0000;
			last_q <= 1'b1;
			period <= 16'h0000;
			rises <= 16'h0000;
		end
		else
		begin
			last_q <= pin;
			cnt_q <= cnt_q + 16'h0001;
			if (pin && !last_q)
			begin
				period <= cnt_q;
				rises <= rises + 16'h0001;
				cnt_q <= 16'h0001;
			end
		end
	end
endmodule

// ===== verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import resp_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic gpio_func_o = 1'b0;
	logic gpio_func_oe = 1'b0;
	logic pready, pslverr, pin_o, pin_oe, en, byp, cap;
	logic [31:0] prdata, rd;
	logic [3:0] gain;
	lead_t lead;
	logic x_ra, x_la, x_ll, d_ll, d_ra, d_la, every, constp, err;
	logic [1:0] amp, freq;
	logic [15:0] period, rises;
	logic [15:0] base;
	int error_cnt = 0;
	int checks_done = 0;
	int f[4] = '{64000, 56900, 51200, 46500};

	// The pin is pulled up while nobody drives it.
	wire pin_level = pin_oe ? pin_o : 1'b1;

	always #50 clock = ~clock;

	resp_ctrl u_resp_ctrl (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .gpio_func_o(gpio_func_o),
		.gpio_func_oe(gpio_func_oe), .general_pin_three_o(pin_o),
		.general_pin_three_oe(pin_oe), .respiration_enable(en),
		.ext_amp_bypass(byp), .ext_capacitor_sel(cap), .gain_mult(gain),
		.measure_lead_sel(lead), .ext_in_right_arm(x_ra),
		.ext_in_left_arm(x_la), .ext_in_left_leg(x_ll),
		.drive_out_left_leg(d_ll), .drive_out_right_arm(d_ra),
		.drive_out_left_arm(d_la), .tone_amplitude_sel(amp),
		.carrier_freq_sel(freq), .every_cycle_periodic(every),
		.sync_constant_period(constp));

	sync_receiver u_sync_receiver (.clock(clock), .rst(rst),
		.pin(pin_level), .period(period), .rises(rises));

	// Report the counts and end the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compare one observed value against its expectation.
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask

	// One APB transfer; two idle edges let decoded outputs settle after it.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			n++;
		end
		if (n == 20)
		begin
			error_cnt++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, CTRL_ADDR, 32'h0);
		check(rd, 32'h0, "reset value");
		check({gain, en, d_ra}, {4'h1, 2'b00}, "reset outputs");
		apb(1'b1, CTRL_ADDR, 32'hFFFFFFFF);
		apb(1'b0, CTRL_ADDR, 32'h0);
		check(rd, 32'h0001FFFF, "upper bits");
		apb(1'b0, 8'h20, 32'h0);
		check({err, rd}, {1'b1, 32'h0}, "unmapped read");
		$display("test register done");
		for (int c = 0; c < 16; c++)
		begin
			apb(1'b1, CTRL_ADDR, 32'(c) << 8);
			check(gain, (c > 9) ? 10 : c + 1, "gain");
		end
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, CTRL_ADDR, 32'(i) << 5);
			check({lead, x_ra, x_la, x_ll}, {i[1:0], i[1:0] == 2'b11,
				i[1:0] == 2'b11 && i[2], i[1:0] == 2'b11 && !i[2]},
				"lead");
		end
		apb(1'b0, STATUS_ADDR, 32'h0);
		check(rd, 32'h00000301, "status");
		for (int a = 0; a < 4; a++)
		begin
			apb(1'b1, CTRL_ADDR, (32'(a) << 3) | (32'(3 - a) << 1)
				| 32'h4000);
			check({byp, amp, freq, every}, {1'b1, a[1:0], 2'(3 - a), 1'b0},
				"tone");
		end
		$display("test fields done");
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, CTRL_ADDR, 32'(i[0]) | (32'(i[1]) << 12)
				| (32'(i[2]) << 13));
			check({en, cap, d_ra}, {i[0], i[1], i[0]}, "drive");
			if (!i[1])
				check({d_ll, d_la}, {i[0] && !i[2], i[0] && i[2]},
					"pair");
			else
				check({d_ll, d_la}, 2'b00, "cap pair");
		end
		$display("test drive done");
		gpio_func_o <= 1'b1;
		gpio_func_oe <= 1'b1;
		apb(1'b1, CTRL_ADDR, 32'h00010001);
		check({pin_o, pin_oe, constp}, 3'b110, "normal pin");
		gpio_func_o <= 1'b0;
		gpio_func_oe <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, CTRL_ADDR, 32'h00018001 | (32'(k) << 1));
			repeat (700) @(posedge clock);
			check({pin_oe, constp, every}, 3'b111, "sync on");
			check(period, (10000000 + f[k] / 2) / f[k], "period");
		end
		apb(1'b1, CTRL_ADDR, 32'h00008001);
		base = rises;
		repeat (700) @(posedge clock);
		check({pin_oe, constp, every}, 3'b100, "fractional");
		check(16'(rises - base) >= 16'h0003, 1'b1, "toggling");
		check(period == 16'(CLK_HZ / F_N0) ||
			period == 16'(CLK_HZ / F_N0 + 1), 1'b1, "mean rate");
		$display("test sync done");
		summarize();
	end
endmodule
